//--- hw/dts_defs.vh
// Constants, register map and timing figures for the digital I/O and trigger block.
// Contract
// - Each of the eight digital lines has its own direction bit, input or output.
// - After reset every digital line is an input until software says otherwise.
// - An input line reads 1 for a high pin and 0 for a low pin.
// - A 32-bit event count rises by one on each low-to-high edge of the count pin.
// - The event counter misses no rising edge for input rates up to 1 MHz.
// - The sync pin is two-way with a direction bit that resets to input.
// - With sync as input each external pacing edge starts one conversion.
// - With sync as output the internal pacer clock is driven onto the pin.
// - A master drives its pacer out while a slave takes pacing from its pin.
// - Software selects whether the trigger input is edge or level sensitive.
// - Edge mode fires on the chosen edge and level mode on the chosen level.
// - Conversion results are offset binary with zero volts at code 32768.
// - With triggering enabled a started paced scan waits for the trigger.
`ifndef DTS_DEFS_VH
`define DTS_DEFS_VH
`define DTS_OFF_DIR      12'h000
`define DTS_OFF_OUT      12'h004
`define DTS_OFF_IN       12'h008
`define DTS_OFF_COUNT    12'h00c
`define DTS_OFF_CTRL     12'h010
`define DTS_OFF_STATUS   12'h014
`define DTS_OFF_PACER    12'h018
`define DTS_OFF_ADC      12'h01c
`define DTS_CTRL_SYNC_OUT   0
`define DTS_CTRL_TRIG_EN    1
`define DTS_CTRL_TRIG_LEVEL 2
`define DTS_CTRL_TRIG_POL   3
`define DTS_CTRL_START      4
`define DTS_CTRL_STOP       5
`define DTS_CTRL_CNT_CLR    6
`define DTS_ST_ARMED        0
`define DTS_ST_RUN          1
`define DTS_ST_SYNC_IN      2
`define DTS_ST_EXTERNAL_TRIGGER_PIN      3
`define DTS_DIR_RESET       8'h00
`define DTS_PACER_RESET     32'h000004e1
`define DTS_ADC_MID         16'h8000
`define DTS_CLK_KHZ         125000
`define DTS_CNT_MAX_KHZ     1000
`define DTS_SYNC_MAX_KHZ    100
`define DTS_CNT_MIN_CYC     (`DTS_CLK_KHZ / `DTS_CNT_MAX_KHZ)
`endif

//--- hw/dts_core.v
// Digital lines, event counter, sync pin and trigger with an APB register file.
`timescale 1ns/1ps
`include "dts_defs.vh"
module dts_core #(
   parameter LINES = 8,
   parameter CW    = 32
) (
   // APB slave
   input  wire              pclk,
   input  wire              presetn,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [11:0]       paddr,
   input  wire [31:0]       pwdata,
   output wire              pready,
   output wire              pslverr,
   output reg  [31:0]       prdata,
   // Digital lines
   input  wire [LINES-1:0]  digital_line_i,
   output reg  [LINES-1:0]  digital_line_o,
   output reg  [LINES-1:0]  digital_line_oe,
   // Counter and trigger pins
   input  wire              event_count_input,
   input  wire              external_trigger_pin,
   // Sync pin
   input  wire              sync_i,
   output reg               sync_o,
   output reg               sync_oe,
   // Converter side
   output reg               conv_start,
   input  wire              adc_valid,
   input  wire [15:0]       adc_data,
   output reg               scan_active
);

   // Two-flop synchronisers; stage one feeds only stage two.
   reg [LINES+2:0] sync_a;
   reg [LINES+2:0] sync_b;
   reg             cnt_d;
   reg             sy_d;
   reg             tr_d;
   reg [CW-1:0]    count;
   reg [7:0]       ctrl;
   reg [31:0]      pacer_div;
   reg [31:0]      pacer_cnt;
   reg             pacer_clk;
   reg             armed;
   reg [15:0]      adc_word;
   reg [31:0]      next_prdata;
   reg [1:0]       scan_state;
   reg [1:0]       next_scan_state;

   // Scan sequencer states.
   localparam [1:0] SCAN_IDLE  = 2'b00;
   localparam [1:0] SCAN_ARMED = 2'b01;
   localparam [1:0] SCAN_RUN   = 2'b10;

   wire [LINES-1:0] line_s = sync_b[LINES-1:0];
   wire cnt_s  = sync_b[LINES];
   wire sy_s   = sync_b[LINES+1];
   wire tr_s   = sync_b[LINES+2];
   wire wr     = psel & penable & pwrite;
   wire rd_setup = psel & ~penable & ~pwrite;
   wire sync_out_mode = ctrl[`DTS_CTRL_SYNC_OUT];
   wire pacer_rise;
   wire pacer_wrap;
   wire ext_rise;
   wire conv_pace;
   wire trig_hit;
   wire ctrl_wr;
   wire start_req;
   wire stop_req;
   wire clear_req;
   wire [3:0] status_bits;

   // True when the current access phase writes the given offset.
   function reg_hit;
      input        write;
      input [11:0] addr;
      input [11:0] offset;
      begin
         reg_hit = write & (addr == offset);
      end
   endfunction

   // Rising edge of a synchronised level against its last sample.
   function rise;
      input now;
      input last;
      begin
         rise = now & ~last;
      end
   endfunction

   // Falling edge of a synchronised level against its last sample.
   function fall;
      input now;
      input last;
      begin
         fall = ~now & last;
      end
   endfunction

   // Places a line vector in the low bits of a bus word.
   function [31:0] line_word;
      input [LINES-1:0] v;
      begin
         line_word = 32'h00000000;
         line_word[LINES-1:0] = v;
      end
   endfunction

   assign ctrl_wr   = reg_hit(wr, paddr, `DTS_OFF_CTRL);
   assign start_req = ctrl_wr & pwdata[`DTS_CTRL_START];
   assign stop_req  = ctrl_wr & pwdata[`DTS_CTRL_STOP];
   assign clear_req = ctrl_wr & pwdata[`DTS_CTRL_CNT_CLR];

   // A 125 MHz sample of a 1 MHz input leaves 62.5 cycles per half period.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= {(LINES+3){1'b0}};
      end else begin
         sync_a <= {external_trigger_pin, sync_i, event_count_input,
                    digital_line_i};
      end
   end

   // Second stage; nothing else reads the first stage.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_b <= {(LINES+3){1'b0}};
      end else begin
         sync_b <= sync_a;
      end
   end

   // Last samples for the edge detectors, reset to the low idle level.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_d <= 1'b0;
         sy_d  <= 1'b0;
         tr_d  <= 1'b0;
      end else begin
         cnt_d <= cnt_s;
         sy_d  <= sy_s;
         tr_d  <= tr_s;
      end
   end

   // Event counter counts every rising edge seen after synchronising.
   // An edge beats a clear in the same cycle so no count is lost.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= {CW{1'b0}};
      end else if (rise(cnt_s, cnt_d)) begin
         count <= count + {{(CW-1){1'b0}}, 1'b1};
      end else if (clear_req) begin
         count <= {CW{1'b0}};
      end
   end

   // Internal pacer: toggles once every programmed half period.
   assign pacer_wrap = (pacer_cnt >= pacer_div);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pacer_cnt <= 32'h00000000;
         pacer_clk <= 1'b0;
      end else if (!scan_active || pacer_wrap) begin
         pacer_cnt <= 32'h00000000;
         pacer_clk <= scan_active & ~pacer_clk;
      end else begin
         pacer_cnt <= pacer_cnt + 32'h00000001;
      end
   end
   assign pacer_rise = pacer_wrap & scan_active & ~pacer_clk;
   assign ext_rise   = rise(sy_s, sy_d);

   // Trigger detect: edge or level, polarity selectable.
   assign trig_hit = ctrl[`DTS_CTRL_TRIG_LEVEL] ?
      (tr_s ~^ ctrl[`DTS_CTRL_TRIG_POL]) :
      (ctrl[`DTS_CTRL_TRIG_POL] ? rise(tr_s, tr_d) :
                                  fall(tr_s, tr_d));

   // Digital line direction; every line resets to input.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         digital_line_oe <= `DTS_DIR_RESET;
      end else if (reg_hit(wr, paddr, `DTS_OFF_DIR)) begin
         digital_line_oe <= pwdata[LINES-1:0];
      end
   end

   // Output levels; a line shows its level only while it drives.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         digital_line_o <= {LINES{1'b0}};
      end else if (reg_hit(wr, paddr, `DTS_OFF_OUT)) begin
         digital_line_o <= pwdata[LINES-1:0];
      end
   end

   // Pacer half period in clock cycles, less one.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pacer_div <= `DTS_PACER_RESET;
      end else if (reg_hit(wr, paddr, `DTS_OFF_PACER)) begin
         pacer_div <= pwdata;
      end
   end

   // Only the mode bits are kept; the strobes act once and read as zero.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 8'h00;
      end else if (ctrl_wr) begin
         ctrl <= {4'h0, pwdata[3:0]};
      end
   end

   // Scan sequencer: stop wins over start, and a start with the trigger
   // enabled waits in the armed state for the trigger condition.
   // A start while running keeps the scan running, or re-arms it with the trigger enabled.
   always @* begin
      next_scan_state = scan_state;
      if (stop_req) begin
         next_scan_state = SCAN_IDLE;
      end else if (start_req && pwdata[`DTS_CTRL_TRIG_EN]) begin
         next_scan_state = SCAN_ARMED;
      end else if (start_req) begin
         next_scan_state = SCAN_RUN;
      end else begin
         case (scan_state)
            SCAN_ARMED: begin
               if (trig_hit)
                  next_scan_state = SCAN_RUN;
            end
            SCAN_RUN:  next_scan_state = SCAN_RUN;
            SCAN_IDLE: next_scan_state = SCAN_IDLE;
            default:   next_scan_state = SCAN_IDLE;
         endcase
      end
   end

   // State register with its two decoded outputs.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_state  <= SCAN_IDLE;
         armed       <= 1'b0;
         scan_active <= 1'b0;
      end else begin
         scan_state  <= next_scan_state;
         armed       <= (next_scan_state == SCAN_ARMED);
         scan_active <= (next_scan_state == SCAN_RUN);
      end
   end

   // Master paces from its own pacer, slave from the pin.
   assign conv_pace = sync_out_mode ? pacer_rise : ext_rise;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_start <= 1'b0;
      end else begin
         conv_start <= scan_active & conv_pace;
      end
   end

   // Sync pin direction and level; the pin stays an input until
   // software asks for export.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_oe <= 1'b0;
         sync_o  <= 1'b0;
      end else begin
         sync_oe <= sync_out_mode;
         sync_o  <= sync_out_mode & pacer_clk;
      end
   end

   // Last converter word.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_word <= `DTS_ADC_MID;
      end else if (adc_valid) begin
         adc_word <= adc_data;
      end
   end

   // Status: trigger pin, sync pin, running, armed.
   assign status_bits = {tr_s, sy_s, scan_active, armed};

   // Zero volts reads as mid-scale; this is the raw offset-binary code.
   always @* begin
      next_prdata = 32'h00000000;
      case (paddr)
         `DTS_OFF_DIR: begin
            next_prdata = line_word(digital_line_oe);
         end
         `DTS_OFF_OUT: begin
            next_prdata = line_word(digital_line_o);
         end
         // Every line, output or input, reads back its synchronised pin.
         `DTS_OFF_IN: begin
            next_prdata = line_word(line_s);
         end
         `DTS_OFF_COUNT: begin
            next_prdata = count;
         end
         `DTS_OFF_CTRL: begin
            next_prdata[7:0] = ctrl;
         end
         `DTS_OFF_STATUS: begin
            next_prdata[3:0] = status_bits;
         end
         `DTS_OFF_PACER: begin
            next_prdata = pacer_div;
         end
         `DTS_OFF_ADC: begin
            next_prdata[15:0] = adc_word;
         end
         default: begin
            next_prdata = 32'h00000000;
         end
      endcase
   end

   // Read data is taken in the setup cycle and stands through access.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         prdata <= next_prdata;
      end
   end

   // Zero wait states: every access phase completes at once.
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

endmodule // dts_core

//--- test/dts_core_assertions.sv
// Port-level checks for the digital I/O and trigger block.
`timescale 1ns/1ps
module dts_chk (
   // Bus
   input wire logic        pclk, presetn, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   // Pins and scan
   input wire logic [7:0]  digital_line_i, digital_line_o, digital_line_oe,
   input wire logic        external_trigger_pin, sync_oe, conv_start,
   input wire logic        scan_active
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr = psel && penable && pwrite;
   wire rd = psel && !penable && !pwrite;
   AST_RST_IN: assert property ($rose(presetn) |->
      digital_line_oe == 8'h00 && !sync_oe) else $error("not inputs");
   AST_DIR: assert property (wr && paddr == 12'h000 |=>
      digital_line_oe == $past(pwdata[7:0])) else $error("dir");
   AST_OUT: assert property (wr && paddr == 12'h004 |=>
      digital_line_o == $past(pwdata[7:0])) else $error("out");
   AST_SYNC: assert property (wr && paddr == 12'h010 |-> ##2
      sync_oe == $past(pwdata[0], 2)) else $error("sync dir");
   AST_IN: assert property ($stable(digital_line_i)[*4] ##0
      (rd && paddr == 12'h008) |=> prdata[7:0] == $past(digital_line_i))
      else $error("in");
   AST_TRIG: assert property ($stable(external_trigger_pin)[*4] ##0
      (rd && paddr == 12'h014) |=> prdata[3] == $past(external_trigger_pin))
      else $error("trig pin");
   AST_CONV: assert property (conv_start |=> !conv_start)
      else $error("conv");
   AST_STOP: assert property (wr && paddr == 12'h010 && pwdata[5] |->
      ##[1:2] !scan_active) else $error("stop");
endmodule // dts_chk
bind dts_core dts_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .digital_line_i, .digital_line_o,
   .digital_line_oe, .external_trigger_pin, .sync_oe, .conv_start,
   .scan_active);

//--- test/dts_pins.sv
// Pin-side world: switches, a second unit's pacer and a converter.
`timescale 1ns/1ps
module dts_pins (
   input wire logic [7:0]   sw, digital_line_o, digital_line_oe,
   output wire logic [7:0]  digital_line_i,
   input wire logic         pclk, pace, sync_o, sync_oe, conv_start,
   output wire logic        sync_i,
   output logic             adc_valid = 1'b0,
   output wire logic [15:0] adc_data
);
   // A driven line shows its own value, so a read-back sees the output.
   assign digital_line_i = digital_line_oe & digital_line_o |
      ~digital_line_oe & sw;
   // The far unit paces at 100 kHz; the pin follows whoever drives.
   assign sync_i = sync_oe ? sync_o : pace;
   assign adc_data = 16'h8000;
   always @(posedge pclk) adc_valid <= conv_start;
endmodule // dts_pins

//--- test/daq_digital_io_trigger_sync_test.sv
// Self-checking bench for the digital I/O, counter, sync and trigger block.
`timescale 1ns/1ps
module daq_digital_io_trigger_sync_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, s;
   logic event_count_input = 0, external_trigger_pin = 0, pace = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, lfsr = 32'h5359b7fe, q[$];
   logic [7:0] sw = 0;
   wire [31:0] prdata;
   wire [15:0] adc_data;
   wire [7:0] digital_line_i, digital_line_o, digital_line_oe;
   wire pready, sync_i, sync_o, sync_oe, conv_start, adc_valid, scan_active;
   int err_count = 0, samples_checked = 0, nconv = 0, n;
   always #4 pclk = ~pclk;
   dts_core i_dut (.*, .pslverr());
   dts_pins i_pins (.*);
   always @(posedge pclk) nconv += (conv_start === 1'b1);
   always @(posedge pclk)
      if (psel && penable && !pwrite && pready && q.size())
         chk(prdata, q.pop_front());
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      wrap_up;
   end
   function automatic logic [31:0] nxt(logic [31:0] v);
      return {v[30:0], ^(v & 32'h80200003)};
   endfunction
   task chk(logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task xfer(logic [11:0] a, logic w, logic [31:0] d);
      if (!w) q.push_back(d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1);
      {psel, penable} <= 0;
   endtask
   task pulses(logic p, int k, hi, lo);
      repeat (k) begin
         if (p) pace <= 1;
         else event_count_input <= 1;
         repeat (hi) @(posedge pclk);
         {pace, event_count_input} <= 0;
         repeat (lo) @(posedge pclk);
      end
   endtask
   task wrap_up;
      $display("checked %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      xfer(12'h000, 0, 0);
      xfer(12'h010, 0, 0);
      xfer(12'h01c, 0, 32'h8000);
      xfer(12'h020, 0, 0);
      repeat (4) begin
         lfsr = nxt(lfsr);
         xfer(12'h000, 1, lfsr[7:0]);
         xfer(12'h004, 1, lfsr[15:8]);
         sw <= lfsr[23:16];
         repeat (5) @(posedge pclk);
         n = lfsr[7:0] & lfsr[15:8] | ~lfsr[7:0] & lfsr[23:16];
         xfer(12'h008, 0, n);
      end
      $display("lines done");
      // A 125-cycle period is exactly the fastest rate the counter must take.
      pulses(0, 5, 62, 63);
      xfer(12'h00c, 0, 5);
      xfer(12'h010, 1, 32'h50);
      pulses(1, 3, 20, 1230);
      chk(nconv, 3);
      xfer(12'h00c, 0, 0);
      xfer(12'h018, 1, 2);
      xfer(12'h010, 1, 32'h11);
      repeat (9) @(posedge pclk);
      @(negedge pclk);
      n = 0;
      repeat (60) begin
         s = sync_o;
         @(negedge pclk);
         n += (sync_o !== s);
      end
      chk(n, 20);
      $display("count and sync done");
      for (int m = 0; m < 4; m++) begin
         xfer(12'h010, 1, 32'h20);
         external_trigger_pin <= ~m[0];
         repeat (5) @(posedge pclk);
         xfer(12'h010, 1, {27'h1, m[0], m[1], 2'b10});
         xfer(12'h014, 0, {~m[0], 3'b001});
         external_trigger_pin <= m[0];
         repeat (10) @(posedge pclk);
         chk(scan_active, 1);
      end
      $display("trigger done");
      wrap_up;
   end
endmodule // daq_digital_io_trigger_sync_test
